// ### include/gdfr_consts.svh
// timing, bit positions and reset values of the gate drive fault recovery block
`ifndef GDFR_CONSTS_SVH
`define GDFR_CONSTS_SVH

`define GDFR_CLK_PERIOD_NS  10
`define GDFR_LOSS_TIME_NS   10000
`define GDFR_LOSS_CYCLES    (`GDFR_LOSS_TIME_NS / `GDFR_CLK_PERIOD_NS)

`define GDFR_NUM_IN         9
`define GDFR_IN_A_POS       0
`define GDFR_IN_B_POS       1
`define GDFR_IN_A_NEG       2
`define GDFR_IN_B_NEG       3
`define GDFR_IN_EXT_N       4
`define GDFR_IN_HOT         5
`define GDFR_IN_COOL        6
`define GDFR_IN_SUP_OK      7
`define GDFR_IN_PWR_DET     8
// sync reset: only the external fault input resets high
`define GDFR_SYNC_RESET     9'h010

`define GDFR_GATE_BOOT      4'h5
`define GDFR_GATE_OFF       4'h0
`define GDFR_FAULT_NONE     4'h0
`define GDFR_FAULT_UV_ONLY  4'h2

`endif

// ### include/gdfr_pkg.sv
// types of the gate drive fault recovery block
package gdfr_pkg;
    typedef enum logic [2:0] {
        GDFR_ST_BOOT = 3'h1,
        GDFR_ST_PROT = 3'h2,
        GDFR_ST_RUN  = 3'h4
    } gdfr_state_t;

    typedef struct packed {
        logic hi_a;
        logic lo_a;
        logic hi_b;
        logic lo_b;
    } gdfr_gate_t;

    typedef struct packed {
        logic ext;
        logic therm;
        logic uv;
        logic loss;
    } gdfr_fault_t;
endpackage

// ### hw/gdfr_top.sv
// protection latch and recovery logic of a dual half-bridge gate driver
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_consts.svh"
module gdfr_top #(
    parameter int LOSS_CYCLES = `GDFR_LOSS_CYCLES  // pwm silence before input loss
) (
    input  wire logic clk_in,             // 100 MHz clock
    input  wire logic rst_in,             // async reset, active high
    input  wire logic chan_a_pwm_pos_in,  // channel a positive pwm
    input  wire logic chan_b_pwm_pos_in,  // channel b positive pwm
    input  wire logic chan_a_pwm_neg_in,  // channel a negative pwm
    input  wire logic chan_b_pwm_neg_in,  // channel b negative pwm
    input  wire logic ext_fault_n_in,     // external fault, active low
    input  wire logic thermal_sense_in,   // thermistor above half supply
    input  wire logic thermal_cool_in,    // thermistor below lower threshold
    input  wire logic supply_ok_in,       // supply detector reads normal
    input  wire logic power_det_in,       // supply has reached power-on level
    output logic      high_gate_a_out,    // high-side gate a
    output logic      low_gate_a_out,     // low-side gate a
    output logic      high_gate_b_out,    // high-side gate b
    output logic      low_gate_b_out,     // low-side gate b
    output logic      totem_low_out,      // totem-pole output forced low
    output logic      fault_flag_n_out    // fault indication, active low
);
    localparam int CW = $clog2(LOSS_CYCLES + 1);      // loss counter width
    localparam logic [CW-1:0] LOSS_LIM = CW'(LOSS_CYCLES);
    localparam logic [CW-1:0] LOSS_PRE = CW'(LOSS_CYCLES - 1);

    // three stage input pipeline: two for sync, one for edges
    logic [`GDFR_NUM_IN-1:0] s1_r;   // first sync stage, read by s2 only
    logic [`GDFR_NUM_IN-1:0] s2_r;   // synced level
    logic [`GDFR_NUM_IN-1:0] s3_r;   // delayed level for edge detect
    logic [`GDFR_NUM_IN-1:0] s1_nxt;
    logic [`GDFR_NUM_IN-1:0] s2_nxt;
    logic [`GDFR_NUM_IN-1:0] s3_nxt;
    logic [`GDFR_NUM_IN-1:0] lvl;    // synced levels
    logic [`GDFR_NUM_IN-1:0] rise;   // one-cycle rising edges
    logic [`GDFR_NUM_IN-1:0] fall;   // one-cycle falling edges
    logic                    pos_rise;  // rising edge on either positive input
    logic                    any_edge;  // any pwm activity

    // sync next values
    always_comb begin
        s1_nxt = {power_det_in, supply_ok_in, thermal_cool_in, thermal_sense_in,
                  ext_fault_n_in, chan_b_pwm_neg_in, chan_a_pwm_neg_in,
                  chan_b_pwm_pos_in, chan_a_pwm_pos_in};
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    // sync registers; external fault resets to its idle high level so release
    // gives no false rise on it, all the rest reset low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r <= `GDFR_SYNC_RESET;
            s2_r <= `GDFR_SYNC_RESET;
            s3_r <= `GDFR_SYNC_RESET;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    assign lvl      = s2_r;
    assign rise     = s2_r & ~s3_r;
    assign fall     = ~s2_r & s3_r;
    assign pos_rise = rise[`GDFR_IN_A_POS] | rise[`GDFR_IN_B_POS];
    assign any_edge = |(rise[3:0] | fall[3:0]);

    // input loss watchdog; saturates so the set is a single pulse
    logic [CW-1:0] cnt_r;    // cycles since last pwm edge
    logic [CW-1:0] cnt_nxt;
    logic          loss_set; // watchdog expires this cycle

    always_comb begin
        loss_set = ~any_edge & (cnt_r == LOSS_PRE);
        if (any_edge) begin
            cnt_nxt = '0;
        end else if (cnt_r != LOSS_LIM) begin
            cnt_nxt = cnt_r + CW'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // fault latches for ext, therm and loss, each set beating its own clear; uv follows the supply level
    gdfr_pkg::gdfr_fault_t fault_r;
    gdfr_pkg::gdfr_fault_t fault_nxt;

    always_comb begin
        fault_nxt = fault_r;
        // low level is protection, so the level itself sets
        if (!lvl[`GDFR_IN_EXT_N]) begin
            fault_nxt.ext = 1'b1;
        end else if (rise[`GDFR_IN_EXT_N]) begin
            fault_nxt.ext = 1'b0;
        end
        // hysteresis: hot sets, only cool clears
        if (lvl[`GDFR_IN_HOT]) begin
            fault_nxt.therm = 1'b1;
        end else if (lvl[`GDFR_IN_COOL]) begin
            fault_nxt.therm = 1'b0;
        end
        fault_nxt.uv = ~lvl[`GDFR_IN_SUP_OK];
        // activity after a timeout counts as normal input again
        if (loss_set) begin
            fault_nxt.loss = 1'b1;
        end else if (any_edge) begin
            fault_nxt.loss = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_r <= `GDFR_FAULT_NONE;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // recovery state machine
    gdfr_pkg::gdfr_state_t state_r;
    gdfr_pkg::gdfr_state_t state_nxt;
    logic                  all_clear;  // no fault latched now and none latched on the next edge
    logic                  hard_off;   // a fault that turns every gate off
    logic                  boot_pat;   // bootstrap charging pattern chosen

    always_comb begin
        // a fault cleared on this very edge waits for the next one
        all_clear = (fault_r == `GDFR_FAULT_NONE) &&
                    (fault_nxt == `GDFR_FAULT_NONE);
        state_nxt = state_r;
        case (state_r)
            gdfr_pkg::GDFR_ST_BOOT: begin
                // hold charging until supply seen and faults gone
                if (lvl[`GDFR_IN_PWR_DET] && all_clear && pos_rise) begin
                    state_nxt = gdfr_pkg::GDFR_ST_RUN;
                end
            end
            gdfr_pkg::GDFR_ST_PROT: begin
                if (all_clear && pos_rise) begin
                    state_nxt = gdfr_pkg::GDFR_ST_RUN;
                end
            end
            gdfr_pkg::GDFR_ST_RUN: begin
                // any fault, with no priority among them, leaves run at once
                if (fault_nxt != `GDFR_FAULT_NONE) begin
                    state_nxt = gdfr_pkg::GDFR_ST_PROT;
                end
            end
            default: begin
                state_nxt = gdfr_pkg::GDFR_ST_PROT;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= gdfr_pkg::GDFR_ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // output drive; loss is ignored in boot so the caps still charge
    gdfr_pkg::gdfr_gate_t gate_r;
    gdfr_pkg::gdfr_gate_t gate_nxt;
    logic                 totem_r;
    logic                 totem_nxt;
    logic                 flag_n_r;
    logic                 flag_n_nxt;

    always_comb begin
        hard_off = fault_nxt.ext | fault_nxt.therm |
                   (fault_nxt.loss & (state_nxt == gdfr_pkg::GDFR_ST_PROT));
        boot_pat = (state_nxt != gdfr_pkg::GDFR_ST_RUN) & ~hard_off;
        if (state_nxt == gdfr_pkg::GDFR_ST_RUN) begin
            // pass-through; dead time lives outside this block
            gate_nxt = {lvl[`GDFR_IN_A_POS], lvl[`GDFR_IN_A_NEG],
                        lvl[`GDFR_IN_B_POS], lvl[`GDFR_IN_B_NEG]};
        end else if (hard_off) begin
            gate_nxt = `GDFR_GATE_OFF;
        end else begin
            gate_nxt = `GDFR_GATE_BOOT;
        end
        totem_nxt  = boot_pat;
        flag_n_nxt = (state_nxt == gdfr_pkg::GDFR_ST_RUN);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gate_r   <= `GDFR_GATE_BOOT;
            totem_r  <= 1'b1;
            flag_n_r <= 1'b0;
        end else begin
            gate_r   <= gate_nxt;
            totem_r  <= totem_nxt;
            flag_n_r <= flag_n_nxt;
        end
    end

    assign high_gate_a_out  = gate_r.hi_a;
    assign low_gate_a_out   = gate_r.lo_a;
    assign high_gate_b_out  = gate_r.hi_b;
    assign low_gate_b_out   = gate_r.lo_b;
    assign totem_low_out    = totem_r;
    assign fault_flag_n_out = flag_n_r;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_recover_edge: assert property ($rose(fault_flag_n_out) |-> $past(pos_rise))
        else $error("left protection without a positive pwm edge");
    chk_ext_force: assert property (!lvl[`GDFR_IN_EXT_N] |=> !fault_flag_n_out &&
        !high_gate_a_out && !low_gate_a_out && !high_gate_b_out && !low_gate_b_out)
        else $error("external fault did not force gates off");
    chk_ext_release: assert property ($rose(fault_flag_n_out) |-> !$past(fault_r.ext))
        else $error("recovered while external fault latched");
    chk_therm_hold: assert property (fault_r.therm && !lvl[`GDFR_IN_COOL]
        |=> !fault_flag_n_out)
        else $error("overtemperature released early");
    chk_uv_hold: assert property (!lvl[`GDFR_IN_SUP_OK] |=> !fault_flag_n_out)
        else $error("running during undervoltage");
    chk_uv_pattern: assert property (state_r == gdfr_pkg::GDFR_ST_PROT &&
        fault_r == `GDFR_FAULT_UV_ONLY |-> !high_gate_a_out && low_gate_a_out &&
        !high_gate_b_out && low_gate_b_out && totem_low_out)
        else $error("wrong undervoltage gate pattern");
    chk_off_pattern: assert property (state_r == gdfr_pkg::GDFR_ST_PROT &&
        (fault_r.ext || fault_r.therm || fault_r.loss) |-> !high_gate_a_out &&
        !low_gate_a_out && !high_gate_b_out && !low_gate_b_out)
        else $error("gates not all off on fault");
    chk_loss_timeout: assert property (cnt_r == LOSS_PRE && !any_edge
        |=> fault_r.loss ##1 !fault_flag_n_out)
        else $error("input loss not detected");
    chk_loss_clear: assert property (fault_r.loss && any_edge && !loss_set
        |=> !fault_r.loss)
        else $error("input loss not cleared by activity");
    chk_boot_pattern: assert property (state_r == gdfr_pkg::GDFR_ST_BOOT &&
        !fault_r.ext && !fault_r.therm |-> !high_gate_a_out && low_gate_a_out &&
        !high_gate_b_out && low_gate_b_out && totem_low_out)
        else $error("wrong power-on gate pattern");
    chk_flag_low: assert property (fault_r != `GDFR_FAULT_NONE |-> !fault_flag_n_out)
        else $error("fault flag high while protected");
    chk_all_clear: assert property ($rose(fault_flag_n_out) |->
        $past(fault_r) == `GDFR_FAULT_NONE)
        else $error("recovered with a fault still latched");
endmodule
`default_nettype wire

// ### dv/gdfr_pwm_ctrl.sv
// pwm controller model that drives the four pwm inputs of the gate driver
`timescale 1ns/1ps
`default_nettype none
module gdfr_pwm_ctrl #(
    parameter int HALF = 4                // half period of the free-running pwm, in clocks
) (
    input  wire logic       clk_in,       // bench clock
    input  wire logic       run_in,       // free-running pwm while high
    input  wire logic [3:0] hold_in,      // levels held while not running
    output logic      [3:0] pwm_out       // a_pos, a_neg, b_pos, b_neg
);
    int   cnt = 0;                        // clocks into the current half period
    logic ph  = 1'b0;                     // pwm phase
    // pins move after the falling edge so the driver samples settled levels
    always @(negedge clk_in) begin
        if (run_in) begin
            cnt = (cnt + 1) % HALF;
            if (cnt == 0) begin
                ph = ~ph;
            end
            pwm_out <= {ph, ~ph, ~ph, ph};  // b runs in antiphase to a
        end else begin
            pwm_out <= hold_in;           // held levels let outputs settle
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the gate drive fault recovery block
`timescale 1ns/1ps
`default_nettype none
`include "gdfr_consts.svh"
module tb;
    localparam int LOSS = 64;             // short silence limit keeps the run brief
    logic       clk_in  = 1'b0;           // 100 MHz clock
    logic       rst_in  = 1'b1;           // async reset
    logic       ext_n   = 1'b1;           // external fault, active low
    logic       hot     = 1'b0;           // thermistor hot
    logic       cool    = 1'b1;           // thermistor below lower threshold
    logic       sup_ok  = 1'b1;           // supply normal
    logic       pwr_det = 1'b0;           // power-on level reached
    logic       run     = 1'b1;           // pwm free-running
    logic [3:0] hold    = 4'h0;           // pwm levels when held
    wire logic [3:0] pwm;                 // pwm pins
    wire logic [3:0] g;                   // gate outputs, struct order
    wire logic  totem_low;                // totem-pole forced low
    wire logic  flag_n;                   // fault flag, active low
    int         fails     = 0;            // mismatches
    int         cmp_count = 0;            // comparisons made
    gdfr_pkg::gdfr_fault_t m_flt = '0;    // model fault latches
    bit         m_run  = 1'b0;            // model in normal operation
    bit         m_boot = 1'b1;            // model in power-on state
    bit         b_side = 1'b0;            // next recovery edge on channel b

    always #5 clk_in = ~clk_in;

    gdfr_pwm_ctrl gdfr_pwm_ctrl_inst (.clk_in(clk_in), .run_in(run), .hold_in(hold),
        .pwm_out(pwm));
    gdfr_top #(.LOSS_CYCLES(LOSS)) gdfr_top_inst (.clk_in(clk_in), .rst_in(rst_in),
        .chan_a_pwm_pos_in(pwm[3]), .chan_a_pwm_neg_in(pwm[2]),
        .chan_b_pwm_pos_in(pwm[1]), .chan_b_pwm_neg_in(pwm[0]),
        .ext_fault_n_in(ext_n), .thermal_sense_in(hot), .thermal_cool_in(cool),
        .supply_ok_in(sup_ok), .power_det_in(pwr_det),
        .high_gate_a_out(g[3]), .low_gate_a_out(g[2]), .high_gate_b_out(g[1]),
        .low_gate_b_out(g[0]), .totem_low_out(totem_low), .fault_flag_n_out(flag_n));

    // verdict and end of run
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // gate pattern plus totem-pole compare
    task automatic cmp_gates(logic [4:0] exp, logic [4:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] gates totem expected %h seen %h", exp, got);
        end
    endtask

    // fault flag compare
    task automatic cmp_flag(logic exp, logic got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] fault flag expected %h seen %h", exp, got);
        end
    endtask

    // expected pins from the model; cleared faults before recovery show boot pattern
    task automatic check_out();
        gdfr_pkg::gdfr_gate_t eg;
        logic et;
        eg = `GDFR_GATE_BOOT;
        et = 1'b1;
        if (m_run) begin
            eg = pwm;
            et = 1'b0;
        end else if (!m_boot && (m_flt.ext | m_flt.therm | m_flt.loss)) begin
            eg = `GDFR_GATE_OFF;
            et = 1'b0;
        end
        cmp_gates({eg, et}, {g, totem_low});
        cmp_flag(m_run, flag_n);
    endtask

    task automatic step(int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic put(logic [3:0] h);
        run  <= 1'b0;
        hold <= h;
    endtask

    // k: 0 external, 1 thermal, 2 supply, 3 input loss
    task automatic set_fault(int k, bit on);
        case (k)
            0: ext_n <= ~on;
            1: begin
                hot  <= on;
                cool <= ~on;
            end
            2: sup_ok <= ~on;
            default: ;
        endcase
        m_flt[3-k] = on;
        if (on) m_run = 1'b0;
    endtask

    // recovery edge alternates between the two positive inputs
    task automatic recover();
        put(4'h0);
        step(8);
        put(b_side ? 4'h2 : 4'h8);
        b_side = ~b_side;
        step(8);
        m_run = 1'b1;
    endtask

    task automatic fault_cycle(int k);
        put(k == 3 ? 4'h0 : 4'hA);
        step(8);
        check_out();
        set_fault(k, 1'b1);
        step(k == 3 ? LOSS + 16 : 8);
        check_out();
        if (k == 3) begin
            put(4'h8);                    // this rise clears the latch only
            step(8);
            m_flt.loss = 1'b0;
        end else begin
            put(4'h0);
            step(8);
            put(4'h8);
            step(8);
            check_out();
            if (k == 1) begin
                hot <= 1'b0;
                step(8);
                check_out();
            end
            set_fault(k, 1'b0);
            step(8);
        end
        check_out();
        recover();
        check_out();
    endtask

    // everything after the first boot exit
    task automatic main_seq();
        for (int i = 0; i < 4; i++) begin
            put(4'($urandom));
            step(8);
            check_out();
        end
        for (int k = 0; k < 4; k++) fault_cycle(k);
        put(4'hA);
        step(8);
        set_fault(0, 1'b1);
        set_fault(2, 1'b1);
        step(8);
        check_out();
        set_fault(0, 1'b0);
        step(8);
        recover();
        m_run = 1'b0;
        check_out();
        set_fault(2, 1'b0);
        step(8);
        recover();
        check_out();
        // second reset: input loss in boot must keep the charging pattern
        rst_in  <= 1'b1;
        pwr_det <= 1'b0;
        step(2);
        rst_in  <= 1'b0;
        m_run  = 1'b0;
        m_boot = 1'b1;
        step(LOSS + 16);
        check_out();
        pwr_det <= 1'b1;
        recover();
        m_boot = 1'b0;
        check_out();
    endtask

    initial begin
        void'($urandom(32'h5fd4));
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_in <= 1'b0;
        step(20);
        check_out();
        pwr_det <= 1'b1;
        for (int i = 0; i < 40 && flag_n !== 1'b1; i++) begin
            step(1);
        end
        m_boot = 1'b0;
        m_run  = 1'b1;
        if (flag_n !== 1'b1) begin
            fails++;                      // boot never left: limit used up
        end else begin
            main_seq();
        end
        end_of_test();
    end
endmodule
`default_nettype wire
